/* hw/iesl_event_status.sv */
// Event flags, status registers, clock stretch and interrupt of a
// two-wire serial interface, with an AXI4-Lite register slave.
// Assumes a byte engine on aclk that pulses the eng_* events, and
// SCL/SDA pins from outside that are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module iesl_event_status
    import iesl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [IESL_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [IESL_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    input wire logic eng_start_done,
    input wire logic eng_addr_sent,
    input wire logic eng_ten_bit_sent,
    input wire logic eng_byte_done,
    input wire logic eng_byte_is_tx,
    input wire logic eng_byte_is_addr,
    input wire logic eng_ack_fail,
    input wire logic eng_arb_lost,
    input wire logic eng_bus_fault,
    input wire logic eng_addr_valid,
    input wire logic [7:0] eng_rx_addr,
    input wire logic [7:0] eng_rx_data,
    input wire logic halt_mode,
    input wire logic global_mask,
    output logic [7:0] tx_data,
    output logic [7:0] ctrl,
    output logic ack_allow,
    output logic irq,
    output logic wake
);
    logic aw_hold_q, w_hold_q, wr_fire, rd_fire;
    logic [IESL_AW-1:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_strb_q;
    logic [7:0] cr_q, oar_q, imsk_q, ist_q, flg_q, flg_d;
    logic [7:0] ev_set, ev_clr, sr1_val, sr2_val;
    logic adds_q, bd_pend_q, msl_q, seen_q, supp_q;
    logic scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q, sda_d_q;
    logic pe, run, stop_cond, match;
    logic sr1_rd, sr2_rd, dr_rd, dr_wr, cr_wr, stop_rel, bd_ok;
    logic adds_set, adds_clr, bd_defer, any_event;

    assign pe = cr_q[IESL_CR_PE];
    assign run = pe & ~halt_mode;
    assign wr_fire = aw_hold_q & w_hold_q & ~s_axi_bvalid;
    assign rd_fire = s_axi_arvalid & s_axi_arready;

    // AXI4-Lite write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 8'h00;
            w_strb_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= IESL_OKAY;
        end else begin
            s_axi_awready <= ~aw_hold_q & ~s_axi_awready ? 1'b1
                : s_axi_awready & ~s_axi_awvalid;
            s_axi_wready <= ~w_hold_q & ~s_axi_wready ? 1'b1
                : s_axi_wready & ~s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_strb_q <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_q[1:0] == 2'h0
                    && aw_addr_q <= IESL_IMSK_OFS)
                    ? IESL_OKAY : IESL_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
            end
        end
    end

    // Write strobes that have side effects
    assign cr_wr = wr_fire & w_strb_q & aw_addr_q == IESL_CR_OFS;
    assign dr_wr = wr_fire & w_strb_q & aw_addr_q == IESL_DR_OFS;
    // Reads with side effects
    assign sr1_rd = rd_fire & s_axi_araddr == IESL_SR1_OFS;
    assign sr2_rd = rd_fire & s_axi_araddr == IESL_SR2_OFS;
    assign dr_rd = rd_fire & s_axi_araddr == IESL_DR_OFS;

    // Stop request dropped by software releases the lines
    assign stop_rel = cr_wr & cr_q[IESL_CR_STOP] & ~w_data_q[IESL_CR_STOP];

    // Registers frozen in halt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cr_q <= IESL_CR_RST;
            oar_q <= 8'h00;
            imsk_q <= 8'h00;
            tx_data <= 8'h00;
        end else if (!halt_mode && wr_fire && w_strb_q) begin
            case (aw_addr_q)
                IESL_CR_OFS: cr_q <= w_data_q;
                IESL_OAR_OFS: oar_q <= w_data_q;
                IESL_IMSK_OFS: imsk_q <= w_data_q;
                IESL_DR_OFS: tx_data <= w_data_q;
                default: ;
            endcase
        end
    end

    // Pin synchronisers; first stages feed only second stages
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_d_q <= 1'b1;
        end else begin
            scl_s1_q <= scl_i;
            scl_s2_q <= scl_s1_q;
            sda_s1_q <= sda_i;
            sda_s2_q <= sda_s1_q;
            sda_d_q <= sda_s2_q;
        end
    end

    // Stop is SDA rising while SCL is high
    assign stop_cond = scl_s2_q & sda_s2_q & ~sda_d_q;
    assign match = eng_rx_addr[7:1] == oar_q[7:1]
        || eng_rx_addr[7:1] == IESL_GCALL;

    // Address-sent event
    assign adds_set = run & eng_addr_sent;
    assign adds_clr = seen_q & cr_wr;
    assign bd_ok = eng_byte_done & (eng_byte_is_tx | cr_q[IESL_CR_ACK]);
    assign bd_defer = bd_ok & eng_byte_is_addr & (adds_q | adds_set);

    always_comb begin
        ev_set = 8'h00;
        ev_clr = 8'h00;
        ev_set[IESL_EV_SB] = run & eng_start_done;
        ev_set[IESL_EV_TEN_BIT_HEADER_SENT] = run & eng_ten_bit_sent;
        ev_set[IESL_EV_OWN_ADDRESS_MATCHED] = run & eng_addr_valid & match;
        ev_set[IESL_EV_BTF] = run & ((bd_ok & ~bd_defer)
            | (bd_pend_q & adds_clr & ~adds_set));
        ev_set[IESL_EV_AF] = run & eng_ack_fail;
        ev_set[IESL_EV_STOPD] = run & stop_cond & ~supp_q;
        ev_set[IESL_EV_ARBITRATION_LOST] = run & eng_arb_lost;
        ev_set[IESL_EV_BUS_FAULT] = run & eng_bus_fault;
        ev_clr[IESL_EV_SB] = seen_q & dr_wr;
        ev_clr[IESL_EV_TEN_BIT_HEADER_SENT] = seen_q & dr_wr;
        ev_clr[IESL_EV_OWN_ADDRESS_MATCHED] = sr1_rd;
        ev_clr[IESL_EV_BTF] = seen_q & (dr_rd | dr_wr)
            | stop_rel | dr_wr & w_data_q == IESL_DR_RELEASE;
        ev_clr[IESL_EV_AF] = sr1_rd;
        ev_clr[IESL_EV_STOPD] = sr2_rd;
        ev_clr[IESL_EV_ARBITRATION_LOST] = sr2_rd;
        ev_clr[IESL_EV_BUS_FAULT] = sr2_rd;
        // Set beats a clear in the same cycle
        if (halt_mode) begin
            flg_d = flg_q;
        end else if (!pe) begin
            flg_d = 8'h00;
        end else begin
            flg_d = ev_set | (flg_q & ~ev_clr);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flg_q <= 8'h00;
        end else begin
            flg_q <= flg_d;
        end
    end

    // Address-sent flag and the byte_done held back behind it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adds_q <= 1'b0;
            bd_pend_q <= 1'b0;
        end else if (!halt_mode) begin
            adds_q <= pe & (adds_set | (adds_q & ~adds_clr));
            bd_pend_q <= pe & (bd_defer
                | (bd_pend_q & ~(adds_clr & ~adds_set)));
        end
    end

    // controller_role
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            msl_q <= 1'b0;
        end else if (!halt_mode) begin
            if (!pe || stop_cond || eng_arb_lost) begin
                msl_q <= 1'b0;
            end else if (cr_wr && w_data_q[IESL_CR_START]) begin
                msl_q <= 1'b1;
            end
        end
    end

    // Status-one read seen, consumed by the next data read or write, control write or status-two read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seen_q <= 1'b0;
        end else if (!halt_mode) begin
            if (!pe) begin
                seen_q <= 1'b0;
            end else if (sr1_rd) begin
                seen_q <= 1'b1;
            end else if (dr_rd || dr_wr || cr_wr || sr2_rd) begin
                seen_q <= 1'b0;
            end
        end
    end

    // Stop-release while the acknowledge-failure flag is set hides the next stop detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            supp_q <= 1'b0;
        end else if (!halt_mode) begin
            if (!pe || stop_cond) begin
                supp_q <= 1'b0;
            end else if (stop_rel && flg_q[IESL_EV_AF]) begin
                supp_q <= 1'b1;
            end
        end
    end

    assign any_event = |flg_q | adds_q;
    assign sr1_val = {any_event, flg_q[IESL_EV_TEN_BIT_HEADER_SENT], adds_q, 1'b0,
        flg_q[IESL_EV_BTF], flg_q[IESL_EV_OWN_ADDRESS_MATCHED], msl_q,
        flg_q[IESL_EV_SB]};
    assign sr2_val = {3'h0, flg_q[IESL_EV_AF], flg_q[IESL_EV_STOPD],
        1'b0, flg_q[IESL_EV_ARBITRATION_LOST], flg_q[IESL_EV_BUS_FAULT]};

    // AXI4-Lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= IESL_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~rd_fire;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= IESL_OKAY;
                case (s_axi_araddr)
                    IESL_CR_OFS: s_axi_rdata <= {24'h0, cr_q};
                    IESL_SR1_OFS: s_axi_rdata <= {24'h0, sr1_val};
                    IESL_SR2_OFS: s_axi_rdata <= {24'h0, sr2_val};
                    IESL_DR_OFS: s_axi_rdata <= {24'h0, eng_rx_data};
                    IESL_OAR_OFS: s_axi_rdata <= {24'h0, oar_q};
                    IESL_IST_OFS: s_axi_rdata <= {24'h0, ist_q};
                    IESL_IMSK_OFS: s_axi_rdata <= {24'h0, imsk_q};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= IESL_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ist_q <= 8'h00;
        end else if (!halt_mode) begin
            ist_q <= ev_set | (ist_q & ~({8{wr_fire & w_strb_q
                & aw_addr_q == IESL_IST_OFS}} & w_data_q));
        end
    end

    // Interrupt, wake request and pin outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
            wake <= 1'b0;
            scl_o <= 1'b0;
            scl_oe <= 1'b0;
            ctrl <= IESL_CR_RST;
            ack_allow <= 1'b0;
        end else begin
            irq <= cr_q[IESL_CR_ITE] & ~global_mask
                & |(ist_q & imsk_q);
            wake <= ~halt_mode & cr_q[IESL_CR_ITE]
                & |(ist_q & imsk_q);
            scl_o <= 1'b0;
            scl_oe <= pe & (flg_q[IESL_EV_BTF]
                | flg_q[IESL_EV_OWN_ADDRESS_MATCHED]);
            ctrl <= cr_q;
            ack_allow <= run & cr_q[IESL_CR_ACK];
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_OWN_CLR: assert property (pe && !halt_mode && sr1_rd
        && !ev_set[IESL_EV_OWN_ADDRESS_MATCHED] |=> !flg_q[IESL_EV_OWN_ADDRESS_MATCHED])
        else $error("address match flag not cleared by status read");
    AST_BD_RX_CLR: assert property (pe && !halt_mode && seen_q
        && dr_rd && !ev_set[IESL_EV_BTF] |=> !flg_q[IESL_EV_BTF])
        else $error("byte_done not cleared by data read");
    AST_BD_TX_CLR: assert property (pe && !halt_mode && seen_q
        && dr_wr && !ev_set[IESL_EV_BTF] |=> !flg_q[IESL_EV_BTF])
        else $error("byte_done not cleared by data write");
    AST_STOPD_CLR: assert property (pe && !halt_mode && sr2_rd
        && !ev_set[IESL_EV_STOPD] |=> !flg_q[IESL_EV_STOPD])
        else $error("stop flag not cleared by status-two read");
    AST_SB_CLR: assert property (pe && !halt_mode && seen_q
        && dr_wr && !ev_set[IESL_EV_SB] |=> !flg_q[IESL_EV_SB])
        else $error("start flag not cleared");
    AST_ADDS_CLR: assert property (pe && !halt_mode && adds_clr
        && !adds_set |=> !adds_q)
        else $error("address-sent flag not cleared");
    AST_HALT: assert property (halt_mode |=> $stable(flg_q)
        && $stable(cr_q))
        else $error("registers changed in halt");
    AST_PE_OFF: assert property (!pe && !halt_mode
        |=> flg_q == 8'h00 && !msl_q)
        else $error("flags not cleared while disabled");
    AST_STRETCH: assert property (pe && flg_q[IESL_EV_BTF]
        |=> scl_oe && !scl_o)
        else $error("clock not held low while byte_done set");
    AST_IRQ: assert property (cr_q[IESL_CR_ITE] && !global_mask
        && (ist_q & imsk_q) != 8'h00 |=> irq)
        else $error("interrupt not raised");
    AST_EVF: assert property (flg_q != 8'h00 |-> sr1_val[IESL_S1_EVF])
        else $error("any_event low with a flag set");
endmodule : iesl_event_status
`default_nettype wire

/* hw/iesl_pkg.sv */
// Constants for the serial-bus event, status and interrupt block.
// Assumes a 32-bit AXI4-Lite register bus with one register per word.
package iesl_pkg;
    localparam int IESL_AW = 8;
    // Register byte offsets
    localparam logic [7:0] IESL_CR_OFS = 8'h00;
    localparam logic [7:0] IESL_SR1_OFS = 8'h04;
    localparam logic [7:0] IESL_SR2_OFS = 8'h08;
    localparam logic [7:0] IESL_DR_OFS = 8'h0c;
    localparam logic [7:0] IESL_OAR_OFS = 8'h10;
    localparam logic [7:0] IESL_IST_OFS = 8'h14;
    localparam logic [7:0] IESL_IMSK_OFS = 8'h18;
    // control_reg fields
    localparam int IESL_CR_ITE = 0;
    localparam int IESL_CR_STOP = 1;
    localparam int IESL_CR_ACK = 2;
    localparam int IESL_CR_START = 3;
    localparam int IESL_CR_PE = 5;
    localparam logic [7:0] IESL_CR_RST = 8'h00;
    // Event vector layout, shared by flags, irq status and irq mask
    localparam int IESL_EV_SB = 0;
    localparam int IESL_EV_TEN_BIT_HEADER_SENT = 1;
    localparam int IESL_EV_OWN_ADDRESS_MATCHED = 2;
    localparam int IESL_EV_BTF = 3;
    localparam int IESL_EV_AF = 4;
    localparam int IESL_EV_STOPD = 5;
    localparam int IESL_EV_ARBITRATION_LOST = 6;
    localparam int IESL_EV_BUS_FAULT = 7;
    // bus_status_one fields
    localparam int IESL_S1_SB = 0;
    localparam int IESL_S1_MSL = 1;
    localparam int IESL_S1_OWN_ADDRESS_MATCHED = 2;
    localparam int IESL_S1_BTF = 3;
    localparam int IESL_S1_ADDS = 5;
    localparam int IESL_S1_TEN_BIT_HEADER_SENT = 6;
    localparam int IESL_S1_EVF = 7;
    // bus_status_two fields
    localparam int IESL_S2_BUS_FAULT = 0;
    localparam int IESL_S2_ARBITRATION_LOST = 1;
    localparam int IESL_S2_STOPD = 3;
    localparam int IESL_S2_AF = 4;
    // Misc values
    localparam logic [7:0] IESL_DR_RELEASE = 8'hff;
    localparam logic [6:0] IESL_GCALL = 7'h00;
    localparam logic [1:0] IESL_OKAY = 2'h0;
    localparam logic [1:0] IESL_SLVERR = 2'h2;
endpackage : iesl_pkg

/* tb/iesl_bus_model.sv */
// Far-side model: byte engine event pulses and the SCL/SDA wire levels.
// Assumes the block's aclk; one link bit lasts 160 ns (8 cycles).
`timescale 1ns/1ps
`default_nettype none
module iesl_bus_model (
    input wire logic aclk,
    output logic [7:0] ev_q,
    output logic tx_q,
    output logic [7:0] rxa_q,
    output logic [7:0] rxd_q,
    output logic scl_q,
    output logic sda_q
);
    initial begin
        ev_q = 8'h00;
        tx_q = 1'b0;
        rxa_q = 8'h00;
        rxd_q = 8'h00;
        scl_q = 1'b1;
        sda_q = 1'b1;
    end
    // One-cycle event pulse with its qualifiers held afterwards
    task automatic fire(input logic [7:0] ev, input logic tx,
        input logic [7:0] rxa, input logic [7:0] rxd);
        @(posedge aclk);
        ev_q <= ev;
        tx_q <= tx;
        rxa_q <= rxa;
        rxd_q <= rxd;
        @(posedge aclk);
        ev_q <= 8'h00;
        repeat (3) @(posedge aclk);
    endtask : fire
    // SDA rises while SCL is high, then both idle on their pull-ups
    task automatic stop_cond();
        @(posedge aclk);
        scl_q <= 1'b0;
        sda_q <= 1'b0;
        repeat (4) @(posedge aclk);
        scl_q <= 1'b1;
        repeat (4) @(posedge aclk);
        sda_q <= 1'b1;
        repeat (8) @(posedge aclk);
    endtask : stop_cond
endmodule : iesl_bus_model
`default_nettype wire

/* tb/iesl_event_status_tb.sv */
// Register-level bench for the serial-bus event and status block.
// Assumes the AXI4-Lite slave timing and event latencies of the design.
`timescale 1ns/1ps
`default_nettype none
module iesl_event_status_tb
    import iesl_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [1:0] s_axi_bresp;
    logic [1:0] s_axi_rresp;
    logic [1:0] last_rresp;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic halt_mode = 1'b0;
    logic byte_is_addr = 1'b0;
    logic global_mask = 1'b0;
    logic scl_o, scl_oe, ack_allow, irq, wake, m_scl, m_sda, m_tx;
    logic scl_line;
    logic [7:0] tx_data, m_ev, m_rxa, m_rxd;
    int fail_count = 0;
    int samples_checked = 0;
    int cyc_q = 0;
    // SCL wire: pulled up, low whenever the block stretches it
    assign scl_line = (scl_oe === 1'b1) ? 1'b0 : m_scl;
    initial begin
        forever #10 aclk = ~aclk;
    end
    iesl_bus_model i_bus (.aclk(aclk), .ev_q(m_ev), .tx_q(m_tx),
        .rxa_q(m_rxa), .rxd_q(m_rxd), .scl_q(m_scl), .sda_q(m_sda));
    iesl_event_status i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .scl_i(scl_line), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(m_sda), .eng_start_done(m_ev[0]),
        .eng_ten_bit_sent(m_ev[1]), .eng_addr_valid(m_ev[2]),
        .eng_byte_done(m_ev[3]), .eng_ack_fail(m_ev[4]),
        .eng_addr_sent(m_ev[5]), .eng_arb_lost(m_ev[6]),
        .eng_bus_fault(m_ev[7]), .eng_byte_is_tx(m_tx),
        .eng_byte_is_addr(byte_is_addr), .eng_rx_addr(m_rxa),
        .eng_rx_data(m_rxd), .halt_mode(halt_mode),
        .global_mask(global_mask), .tx_data(tx_data), .ctrl(),
        .ack_allow(ack_allow), .irq(irq), .wake(wake));
    task automatic tally_and_finish();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        if (n >= 50) fail_count++;
        repeat (2) @(posedge aclk);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        int n;
        logic [31:0] d;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        d = s_axi_rdata;
        last_rresp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 50) fail_count++;
        chk(d, {24'h0, exp});
        repeat (2) @(posedge aclk);
    endtask : rc
    always @(posedge aclk) begin
        cyc_q <= cyc_q + 1;
        if (cyc_q == 8000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rc(IESL_CR_OFS, 8'h00);
        rc(IESL_SR1_OFS, 8'h00);
        rc(IESL_SR2_OFS, 8'h00);
        rc(8'h1c, 8'h00);
        chk(last_rresp, IESL_SLVERR);
        wr(IESL_IMSK_OFS, 8'hff);
        wr(IESL_OAR_OFS, 8'h3a);
        wr(IESL_CR_OFS, 8'h25);
        chk(ack_allow, 1'b1);
        // Own address, mismatch, then general call
        i_bus.fire(8'h04, 1'b0, 8'h3a, 8'h00);
        chk(scl_oe, 1'b1);
        chk(irq, 1'b1);
        chk(wake, 1'b1);
        rc(IESL_SR1_OFS, 8'h84);
        rc(IESL_SR1_OFS, 8'h00);
        chk(scl_oe, 1'b0);
        i_bus.fire(8'h04, 1'b0, 8'h3c, 8'h00);
        rc(IESL_SR1_OFS, 8'h00);
        i_bus.fire(8'h04, 1'b0, 8'h00, 8'h00);
        rc(IESL_SR1_OFS, 8'h84);
        rc(IESL_SR1_OFS, 8'h00);
        // Received byte, then receive with acknowledge off
        i_bus.fire(8'h08, 1'b0, 8'h00, 8'ha5);
        chk(scl_oe, 1'b1);
        rc(IESL_SR1_OFS, 8'h88);
        rc(IESL_DR_OFS, 8'ha5);
        rc(IESL_SR1_OFS, 8'h00);
        wr(IESL_CR_OFS, 8'h21);
        i_bus.fire(8'h08, 1'b0, 8'h00, 8'h00);
        rc(IESL_SR1_OFS, 8'h00);
        wr(IESL_CR_OFS, 8'h25);
        // Sent byte
        i_bus.fire(8'h08, 1'b1, 8'h00, 8'h00);
        rc(IESL_SR1_OFS, 8'h88);
        wr(IESL_DR_OFS, 8'h12);
        chk(tx_data, 8'h12);
        rc(IESL_SR1_OFS, 8'h00);
        // Acknowledge failure, released by FFh and by stop pulse
        i_bus.fire(8'h18, 1'b1, 8'h00, 8'h00);
        rc(IESL_SR2_OFS, 8'h10);
        rc(IESL_SR1_OFS, 8'h88);
        rc(IESL_SR2_OFS, 8'h00);
        wr(IESL_DR_OFS, IESL_DR_RELEASE);
        rc(IESL_SR1_OFS, 8'h00);
        i_bus.fire(8'h18, 1'b1, 8'h00, 8'h00);
        rc(IESL_SR1_OFS, 8'h88);
        wr(IESL_CR_OFS, 8'h27);
        wr(IESL_CR_OFS, 8'h25);
        rc(IESL_SR1_OFS, 8'h00);
        // Start request, irq masking paths
        wr(IESL_IST_OFS, 8'hff);
        chk(irq, 1'b0);
        wr(IESL_CR_OFS, 8'h2d);
        i_bus.fire(8'h01, 1'b0, 8'h00, 8'h00);
        chk(irq, 1'b1);
        global_mask <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(irq, 1'b0);
        global_mask <= 1'b0;
        wr(IESL_IMSK_OFS, 8'hfe);
        chk(irq, 1'b0);
        wr(IESL_IMSK_OFS, 8'hff);
        chk(irq, 1'b1);
        wr(IESL_IST_OFS, 8'h01);
        chk(irq, 1'b0);
        rc(IESL_SR1_OFS, 8'h83);
        wr(IESL_DR_OFS, 8'h3a);
        rc(IESL_SR1_OFS, 8'h02);
        // Stop on the wire ends controller role
        i_bus.stop_cond();
        rc(IESL_SR1_OFS, 8'h80);
        rc(IESL_SR2_OFS, 8'h08);
        rc(IESL_SR2_OFS, 8'h00);
        i_bus.fire(8'h20, 1'b1, 8'h00, 8'h00);
        rc(IESL_SR1_OFS, 8'ha0);
        wr(IESL_CR_OFS, 8'h25);
        rc(IESL_SR1_OFS, 8'h00);
        // Address byte done waits behind the address-sent event
        byte_is_addr <= 1'b1;
        i_bus.fire(8'h28, 1'b1, 8'h00, 8'h00);
        rc(IESL_SR1_OFS, 8'ha0);
        wr(IESL_CR_OFS, 8'h25);
        rc(IESL_SR1_OFS, 8'h88);
        wr(IESL_DR_OFS, 8'h55);
        rc(IESL_SR1_OFS, 8'h00);
        byte_is_addr <= 1'b0;
        i_bus.fire(8'h02, 1'b1, 8'h00, 8'h00);
        rc(IESL_SR1_OFS, 8'hc0);
        wr(IESL_DR_OFS, 8'hf0);
        rc(IESL_SR1_OFS, 8'h00);
        // Arbitration loss and bus fault together
        wr(IESL_CR_OFS, 8'h2d);
        i_bus.fire(8'hc0, 1'b0, 8'h00, 8'h00);
        rc(IESL_SR1_OFS, 8'h80);
        rc(IESL_SR2_OFS, 8'h03);
        rc(IESL_SR2_OFS, 8'h00);
        // Disable clears pending flags
        wr(IESL_CR_OFS, 8'h2d);
        i_bus.fire(8'h0d, 1'b0, 8'h3a, 8'h00);
        wr(IESL_CR_OFS, 8'h00);
        rc(IESL_SR1_OFS, 8'h00);
        // Halt freezes flags and blocks wake from own events
        wr(IESL_CR_OFS, 8'h25);
        wr(IESL_IST_OFS, 8'hff);
        halt_mode <= 1'b1;
        i_bus.fire(8'h08, 1'b0, 8'h00, 8'h00);
        chk(wake, 1'b0);
        halt_mode <= 1'b0;
        rc(IESL_SR1_OFS, 8'h00);
        rc(IESL_IST_OFS, 8'h00);
        tally_and_finish();
    end
endmodule : iesl_event_status_tb
`default_nettype wire
